/* File: rtl/asd_pkg.sv */
package asd_pkg;
   localparam int ADDR_W = 32;
   localparam int EXT_ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int NUM_BLOCKS = 4;
   localparam int BLOCK_LSB = 30;
   localparam logic [1:0] INT_IO_BLOCK = 2'h3;
   localparam int WAIT_W = 4;
   localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h0;
   // Access size encoding
   typedef enum logic [1:0] {
      ASD_SZ_BYTE = 2'h0,
      ASD_SZ_HALF = 2'h1,
      ASD_SZ_WORD = 2'h2
   } asd_size_t;
   // Bus cycle type chosen per block
   typedef enum logic [1:0] {
      ASD_CYC_NORMAL = 2'h0,
      ASD_CYC_PAGE_ROM = 2'h1,
      ASD_CYC_DRAM = 2'h2
   } asd_cycle_t;
endpackage

/* File: rtl/asd_address_space_decode.sv */
// Overview of operation
// - Drive only low 24 address bits off chip
// - Separate memory and I/O spaces by access kind
// - Four 1G blocks, 16M visible in each
// - I/O block 3 decodes as internal I/O
// - Multi-byte data ordered little-endian
// - Byte, halfword and word access sizes
// - Per-block chip select, wait, cycle type
`timescale 1ns/1ps
`default_nettype none
module asd_address_space_decode (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Internal master request
   input wire logic req_i,
   input wire logic req_is_io_i,
   input wire logic req_write_i,
   input wire logic [1:0] req_size_i,
   input wire logic [31:0] req_addr_i,
   input wire logic [31:0] req_wdata_i,
   // Per-block configuration
   input wire logic [15:0] wait_cfg_i,
   input wire logic [7:0] cycle_cfg_i,
   // External bus
   output logic ext_valid_o,
   output logic [23:0] ext_addr_o,
   output logic ext_mem_o,
   output logic ext_io_o,
   output logic ext_write_o,
   output logic [3:0] ext_byte_en_o,
   output logic [31:0] ext_wdata_o,
   output logic [3:0] block_select_lines_o,
   output logic [3:0] wait_count_o,
   output logic [1:0] cycle_type_o,
   // Internal I/O space and size error
   output logic int_io_valid_o,
   output logic [29:0] int_io_addr_o,
   output logic size_err_o
);
   logic [1:0] blk;
   logic internal_io;
   logic size_ok;
   logic [3:0] next_be;
   logic [31:0] next_wdata;

   assign blk = req_addr_i[asd_pkg::BLOCK_LSB +: 2];
   assign internal_io = req_is_io_i && (blk == asd_pkg::INT_IO_BLOCK);

   // Lanes follow the low address bits; misaligned requests are refused
   always_comb begin
      next_be = 4'h0;
      next_wdata = req_wdata_i;
      size_ok = 1'b0;
      unique case (req_size_i)
         asd_pkg::ASD_SZ_BYTE: begin
            size_ok = 1'b1;
            next_be = 4'h1 << req_addr_i[1:0];
            next_wdata = {4{req_wdata_i[7:0]}};
         end
         asd_pkg::ASD_SZ_HALF: begin
            size_ok = ~req_addr_i[0];
            next_be = req_addr_i[1] ? 4'hc : 4'h3;
            next_wdata = {2{req_wdata_i[15:0]}};
         end
         asd_pkg::ASD_SZ_WORD: begin
            size_ok = (req_addr_i[1:0] == 2'h0);
            next_be = 4'hf;
         end
         default: begin
            size_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ext_valid_o <= 1'b0;
         ext_mem_o <= 1'b0;
         ext_io_o <= 1'b0;
         ext_write_o <= 1'b0;
         ext_addr_o <= 24'h0;
         ext_byte_en_o <= 4'h0;
         ext_wdata_o <= 32'h0;
         block_select_lines_o <= 4'h0;
         wait_count_o <= asd_pkg::WAIT_RESET;
         cycle_type_o <= 2'h0;
      end else begin
         ext_valid_o <= req_i && size_ok && !internal_io;
         ext_mem_o <= req_i && size_ok && !req_is_io_i;
         ext_io_o <= req_i && size_ok && req_is_io_i && !internal_io;
         ext_write_o <= req_i && req_write_i;
         if (req_i) begin
            ext_addr_o <= req_addr_i[asd_pkg::EXT_ADDR_W-1:0];
            ext_byte_en_o <= next_be;
            ext_wdata_o <= next_wdata;
            wait_count_o <= wait_cfg_i[blk*4 +: 4];
            cycle_type_o <= cycle_cfg_i[blk*2 +: 2];
         end
         block_select_lines_o <= (req_i && size_ok && !internal_io) ?
                                 (4'h1 << blk) : 4'h0;
      end
   end

   // Reset is sampled in the antecedent: a request that meets reset is dropped,
   // so the outputs one cycle later still show reset values
   sequence s_take;
      !sys_rst_i && req_i;
   endsequence

   sequence s_take_ext;
      s_take ##0 (size_ok && !internal_io);
   endsequence

   sequence s_take_int;
      s_take ##0 (size_ok && internal_io);
   endsequence

   property p_low_addr;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take |=> ext_addr_o == $past(req_addr_i[23:0]);
   endproperty
   a_low_addr: assert property (p_low_addr)
      else $error("external address not low 24 bits");

   property p_space;
      @(posedge clk_i) disable iff (sys_rst_i)
         !(ext_mem_o && (ext_io_o || int_io_valid_o));
   endproperty
   a_space: assert property (p_space)
      else $error("memory and io both active");

   property p_mem_space;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take ##0 (size_ok && !req_is_io_i) |=> ext_mem_o && !ext_io_o;
   endproperty
   a_mem_space: assert property (p_mem_space)
      else $error("memory access not on memory space");

   property p_io_space;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take_ext ##0 req_is_io_i |=> ext_io_o && !ext_mem_o;
   endproperty
   a_io_space: assert property (p_io_space)
      else $error("io access not on io space");

   property p_onehot;
      @(posedge clk_i) disable iff (sys_rst_i)
         $onehot0(block_select_lines_o);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("more than one block selected");

   property p_block;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take_ext |=> block_select_lines_o[$past(blk)];
   endproperty
   a_block: assert property (p_block)
      else $error("wrong block select");

   property p_select_valid;
      @(posedge clk_i) disable iff (sys_rst_i)
         ext_valid_o == (block_select_lines_o != 4'h0);
   endproperty
   a_select_valid: assert property (p_select_valid)
      else $error("select and valid disagree");

   property p_strobe;
      @(posedge clk_i) disable iff (sys_rst_i)
         !sys_rst_i && !req_i |=> !ext_valid_o && block_select_lines_o == 4'h0;
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("select without request");

   property p_word_be;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take ##0 (req_size_i == 2'h2) |=> ext_byte_en_o == 4'hf;
   endproperty
   a_word_be: assert property (p_word_be)
      else $error("word lanes wrong");

   property p_half_be;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take ##0 (req_size_i == 2'h1 && !req_addr_i[0])
            |=> ext_byte_en_o == ($past(req_addr_i[1]) ? 4'hc : 4'h3);
   endproperty
   a_half_be: assert property (p_half_be)
      else $error("halfword lanes wrong");

   property p_byte_le;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take ##0 (req_size_i == 2'h0 && req_addr_i[1:0] == 2'h0)
            |=> ext_byte_en_o == 4'h1;
   endproperty
   a_byte_le: assert property (p_byte_le)
      else $error("byte lane not little-endian");

   property p_byte_lane;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take ##0 (req_size_i == 2'h0)
            |=> ext_wdata_o[8 * $past(req_addr_i[1:0]) +: 8] == $past(req_wdata_i[7:0]);
   endproperty
   a_byte_lane: assert property (p_byte_lane)
      else $error("byte data not on its lane");

   property p_wait;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take |=> wait_count_o == $past(wait_cfg_i[blk*4 +: 4]);
   endproperty
   a_wait: assert property (p_wait)
      else $error("wait count not from block");

   property p_cycle;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take |=> cycle_type_o == $past(cycle_cfg_i[blk*2 +: 2]);
   endproperty
   a_cycle: assert property (p_cycle)
      else $error("cycle type not from block");

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         int_io_valid_o <= 1'b0;
         int_io_addr_o <= 30'h0;
         size_err_o <= 1'b0;
      end else begin
         int_io_valid_o <= req_i && size_ok && internal_io;
         if (req_i) begin
            int_io_addr_o <= req_addr_i[29:0];
         end
         size_err_o <= req_i && !size_ok;
      end
   end

   property p_int_io;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take_int |=> int_io_valid_o && !ext_valid_o && block_select_lines_o == 4'h0;
   endproperty
   a_int_io: assert property (p_int_io)
      else $error("internal io leaked off chip");

   property p_int_addr;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take_int |=> int_io_addr_o == $past(req_addr_i[29:0]);
   endproperty
   a_int_addr: assert property (p_int_addr)
      else $error("internal io address wrong");

   property p_size_err;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_take ##0 (!size_ok) |=> size_err_o && !ext_valid_o && !int_io_valid_o;
   endproperty
   a_size_err: assert property (p_size_err)
      else $error("bad size or alignment not refused");
endmodule
`default_nettype wire

/* File: verif/asd_ext_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module asd_ext_dev (
   // Bus side
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ext_valid_i,
   input wire logic [3:0] sel_i,
   // Observed traffic
   output logic [3:0] hits_o
);
   // Only strobed cycles with a select reach a device
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hits_o <= 4'h0;
      end else if (ext_valid_i && sel_i != 4'h0) begin
         hits_o <= hits_o + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: verif/tb_address_space_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_address_space_decode;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, req_i = 1'b0, io = 1'b0;
   logic [1:0] sz = 2'h0, ct;
   logic [31:0] addr = 32'h0, ewd;
   logic ev, em, eio, ew, iov, err;
   logic [23:0] ea;
   logic [3:0] be, sel, wc, hits;
   logic [29:0] ia;
   logic [15:0] wcfg = 16'h7531;
   logic [7:0] ccfg = 8'h24;
   logic [31:0] lm;
   int n_mismatch = 0, checks_done = 0;
   // io, size, address / valid, byte enables, select, internal, error
   logic [34:0] stim [8] = '{{1'b0, 2'h0, 32'h00000003}, {1'b0, 2'h1, 32'h40000012},
      {1'b0, 2'h2, 32'h80fffffc}, {1'b0, 2'h2, 32'hc0000000}, {1'b1, 2'h0, 32'h00abcdef},
      {1'b1, 2'h2, 32'hc0000004}, {1'b0, 2'h1, 32'h00000001}, {1'b0, 2'h3, 32'h0}};
   logic [10:0] want [8] = '{11'h604, 11'h708, 11'h7d0, 11'h7e0, 11'h604, 11'h002, 11'h001,
      11'h001};
   always #4 clk_i = ~clk_i;
   asd_address_space_decode DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
      .req_is_io_i(io), .req_write_i(addr[4]), .req_size_i(sz), .req_addr_i(addr),
      .req_wdata_i(addr), .wait_cfg_i(wcfg), .cycle_cfg_i(ccfg), .ext_valid_o(ev),
      .ext_addr_o(ea), .ext_mem_o(em), .ext_io_o(eio), .ext_write_o(ew), .ext_byte_en_o(be),
      .ext_wdata_o(ewd), .block_select_lines_o(sel), .wait_count_o(wc), .cycle_type_o(ct),
      .int_io_valid_o(iov), .int_io_addr_o(ia), .size_err_o(err));
   asd_ext_dev dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_valid_i(ev), .sel_i(sel),
      .hits_o(hits));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk("rst_valid", 32'({ev, sel, iov, err}), 32'h0);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         {io, sz, addr} <= stim[i];
         req_i <= 1'b1;
         @(posedge clk_i);
         req_i <= 1'b0;
         #1;
         lm = {{8{want[i][9]}}, {8{want[i][8]}}, {8{want[i][7]}}, {8{want[i][6]}}};
         chk("valid", 32'(ev), 32'(want[i][10]));
         chk("sel", 32'(sel), 32'(want[i][5:2]));
         chk("int_io", 32'(iov), 32'(want[i][1]));
         chk("err", 32'(err), 32'(want[i][0]));
         chk("space", 32'({em, eio}), 32'({want[i][10] & ~io, want[i][10] & io}));
         chk("write", 32'(ew), 32'(addr[4]));
         chk("cycle", 32'(ct), 32'(ccfg[2 * addr[31:30] +: 2]));
         if (want[i][1]) begin
            chk("int_addr", 32'(ia), 32'(addr[29:0]));
         end
         if (want[i][10]) begin
            chk("addr", 32'(ea), 32'(addr[23:0]));
            chk("blk_addr", 32'(ea), 32'(stim[i][23:0]));
            chk("be", 32'(be), 32'(want[i][9:6]));
            chk("wait", 32'(wc), 32'(wcfg[4 * addr[31:30] +: 4]));
            chk("wdata", ewd & lm, (addr << (8 * addr[1:0])) & lm);
         end
      end
      chk("hits", 32'(hits), 32'h5);
      @(posedge clk_i);
      {io, sz, addr} <= stim[0];
      req_i <= 1'b1;
      sys_rst_i <= 1'b1;
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk("rst_sel", 32'({ev, sel}), 32'h0);
      @(posedge clk_i);
      req_i <= 1'b0;
      #1;
      chk("rst_first", 32'({ev, sel}), 32'({want[0][10], want[0][5:2]}));
      chk("rst_addr", 32'(ea), 32'(stim[0][23:0]));
      wrap_up();
   end
endmodule
`default_nettype wire
